// >>> hdl/dowa_top.sv
// Output converter control: registers, watchdog service, output steering, auto-learn
// Assumes a classic Wishbone master on clk_i; load sense arrives asynchronously
`timescale 1ns/1ps
`include "dowa_map.svh"
module dowa_top
   import dowa_pkg::*;
#(
   parameter int unsigned WDT_CYCLES = `DOWA_WDT_TIME_US * `DOWA_CLK_MHZ
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [9:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic                    crc_err_i,
   input  wire logic [DOWA_CLAMP_W-1:0] load_level_i,
   output logic                         current_output_pin_hiz_o,
   output logic      [3:0]              vsw_closed_o,
   output logic                         alarm_o,
   output logic                         irq_o,
   output logic                         bb_en_o,
   output logic                         bb_track_o,
   output logic      [DOWA_CLAMP_W-1:0] bb_clamp_o,
   output logic                         dac_en_o,
   output logic      [15:0]             dac_code_o
);

   initial begin
      if (WDT_CYCLES < 2) $error("dowa_top: WDT_CYCLES too short");
   end

   typedef struct packed {
      logic                    ack;
      logic [31:0]             rdat;
      logic                    voltage_output_pin_en;
      logic                    current_output_pin_en;
      logic                    voltage_pin_disconnect_bit;
      dowa_bbmode_t            bb_mode;
      dowa_action_t            action;
      logic                    wdt_en;
      logic [DOWA_CLAMP_W-1:0] host_clamp;
      logic [15:0]             code;
      logic [5:0]              alarm_code;
      logic                    mask_wdt;
      logic                    mask_crc;
      logic [2:0]              status;
      logic [2:0]              imask;
      logic                    restart;
      logic                    shut;
      logic [DOWA_CLAMP_W-1:0] load_s1;
      logic [DOWA_CLAMP_W-1:0] load_s2;
      logic                    current_output_pin_hiz;
      logic [3:0]              vsw;
      logic                    alarm;
      logic                    irq;
      logic                    bb_en;
      logic                    bb_track;
      logic [DOWA_CLAMP_W-1:0] bb_clamp;
      logic                    dac_en;
      logic [15:0]             dac_code;
   } dowa_state_t;

   dowa_state_t s_q;
   dowa_state_t s_d;

   logic                    wd_timeout;
   logic                    learned;
   logic [DOWA_CLAMP_W-1:0] learn_clamp;

   dowa_wdog #(
      .PERIOD (WDT_CYCLES)
   ) u_wdog (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .enable_i  (s_q.wdt_en),
      .restart_i (s_q.restart),
      .timeout_o (wd_timeout)
   );

   dowa_learn u_learn (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .current_output_pin_en_i    (s_q.current_output_pin_en),
      .mode_i       (s_q.bb_mode),
      .code_i       (s_q.code),
      .host_clamp_i (s_q.host_clamp),
      .load_i       (s_q.load_s2),
      .clamp_o      (learn_clamp),
      .learned_o    (learned)
   );

   logic        req;
   logic        wr;
   logic [7:0]  idx;
   logic [15:0] wdat;
   logic [2:0]  ev;
   logic        fault;

   always_comb begin
      s_d = s_q;
      req = wb_cyc_i && wb_stb_i && !s_q.ack;
      wr = req && wb_we_i;
      idx = wb_adr_i[9:2];
      wdat = s_q.rdat[15:0];
      ev = 3'b000;

      // Load sense crosses from the analog side
      s_d.load_s1 = load_level_i;
      s_d.load_s2 = s_q.load_s1;

      // Ack one cycle after the request, drops the cycle after
      s_d.ack = req;
      // Restart bit clears itself after one cycle
      s_d.restart = 1'b0;

      // Byte lanes merged over the current contents
      unique case (idx)
         `DOWA_IDX_CTRL: begin
            wdat = {7'h00, s_q.wdt_en, s_q.action, 1'b0, s_q.bb_mode, s_q.voltage_pin_disconnect_bit, s_q.current_output_pin_en, s_q.voltage_output_pin_en};
         end
         `DOWA_IDX_CLAMP:   wdat = {8'h00, s_q.host_clamp};
         `DOWA_IDX_CODE:    wdat = s_q.code;
         `DOWA_IDX_MASK: begin
            wdat = 16'h0000;
            wdat[`DOWA_MASK_WDT] = s_q.mask_wdt;
            wdat[`DOWA_MASK_CRC] = s_q.mask_crc;
         end
         `DOWA_IDX_STATUS:  wdat = {13'h0000, s_q.status};
         `DOWA_IDX_IMASK:   wdat = {13'h0000, s_q.imask};
         `DOWA_IDX_ALMCODE: wdat = {s_q.alarm_code, 10'h000};
         default:           wdat = 16'h0000;
      endcase

      if (req) begin
         // Service register and reserved space read zero
         s_d.rdat = {16'h0000, wdat};
      end

      if (wb_sel_i[0]) begin
         wdat[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
         wdat[15:8] = wb_dat_i[15:8];
      end

      if (wr && idx < `DOWA_IDX_RSVD_LO) begin
         unique case (idx)
            `DOWA_IDX_CTRL: begin
               s_d.voltage_output_pin_en = wdat[`DOWA_CTRL_VOLTAGE_OUTPUT_PIN];
               s_d.current_output_pin_en = wdat[`DOWA_CTRL_CURRENT_OUTPUT_PIN];
               s_d.voltage_pin_disconnect_bit = wdat[`DOWA_CTRL_POC];
               s_d.bb_mode = dowa_bbmode_t'(wdat[`DOWA_CTRL_MODE_LO +: 2]);
               s_d.action = dowa_action_t'(wdat[`DOWA_CTRL_ACT_LO +: 2]);
               s_d.wdt_en = wdat[`DOWA_CTRL_WDT_EN];
            end
            `DOWA_IDX_CLAMP:   s_d.host_clamp = wdat[DOWA_CLAMP_W-1:0];
            `DOWA_IDX_CODE:    s_d.code = wdat;
            `DOWA_IDX_MASK: begin
               s_d.mask_wdt = wdat[`DOWA_MASK_WDT];
               s_d.mask_crc = wdat[`DOWA_MASK_CRC];
            end
            `DOWA_IDX_STATUS:  s_d.status = s_q.status & ~wdat[2:0];
            `DOWA_IDX_IMASK:   s_d.imask = wdat[2:0];
            `DOWA_IDX_ALMCODE: s_d.alarm_code = wdat[15:10];
            `DOWA_IDX_WDSERV: begin
               s_d.restart = wb_sel_i[0] && wb_dat_i[`DOWA_WDS_RESTART];
            end
            default: begin
            end
         endcase
      end

      // Events set after the clear, so a coincident event wins
      ev[`DOWA_ST_WDT] = wd_timeout;
      ev[`DOWA_ST_CRC] = crc_err_i;
      ev[`DOWA_ST_LEARN] = learned;
      s_d.status = s_d.status | ev;

      if ((ev[`DOWA_ST_WDT] || ev[`DOWA_ST_CRC]) && s_q.action == DOWA_ACT_SHUT) begin
         s_d.shut = 1'b1;
      end
      fault = s_q.status[`DOWA_ST_WDT] || s_q.status[`DOWA_ST_CRC];

      // Masked timeout stays off the pin
      s_d.alarm = (s_q.status[`DOWA_ST_WDT] && !s_q.mask_wdt) || (s_q.status[`DOWA_ST_CRC] && !s_q.mask_crc);
      s_d.irq = |(s_q.status & s_q.imask);

      // Current pin floats unless current output active
      s_d.current_output_pin_hiz = !s_q.current_output_pin_en || s_q.shut;
      if (s_q.voltage_output_pin_en && !s_q.shut) begin
         s_d.vsw = 4'b1111;
      end else begin
         s_d.vsw = 4'b0000;
         s_d.vsw[2] = !s_q.voltage_pin_disconnect_bit;
      end

      s_d.bb_en = s_q.bb_mode != DOWA_BB_OFF && s_q.bb_mode != DOWA_BB_RSVD && !s_q.shut;
      s_d.bb_track = s_q.bb_mode == DOWA_BB_TRACK && !learned && u_learn_waiting(s_q.bb_mode);
      // Tracking before learn relies on host order
      s_d.bb_clamp = learn_clamp;
      s_d.dac_en = (s_q.voltage_output_pin_en || s_q.current_output_pin_en) && !s_q.shut;
      // Alarm code forced while fault stands and action is DOWA_ACT_CODE
      if (s_q.action == DOWA_ACT_CODE && fault) begin
         s_d.dac_code = {s_q.alarm_code, 10'h000};
      end else begin
         s_d.dac_code = s_q.code;
      end
   end

   function automatic logic u_learn_waiting(input dowa_bbmode_t m);
      u_learn_waiting = (m == DOWA_BB_TRACK);
   endfunction : u_learn_waiting

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.host_clamp <= `DOWA_RST_CLAMP;
         s_q.current_output_pin_hiz <= 1'b1;
         s_q.vsw <= 4'b0100;
         s_q.bb_clamp <= `DOWA_RST_CLAMP;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.rdat;
   assign wb_ack_o = s_q.ack;
   assign current_output_pin_hiz_o = s_q.current_output_pin_hiz;
   assign vsw_closed_o = s_q.vsw;
   assign alarm_o = s_q.alarm;
   assign irq_o = s_q.irq;
   assign bb_en_o = s_q.bb_en;
   assign bb_track_o = s_q.bb_track;
   assign bb_clamp_o = s_q.bb_clamp;
   assign dac_en_o = s_q.dac_en;
   assign dac_code_o = s_q.dac_code;

endmodule : dowa_top

// >>> hdl/dowa_map.svh
// Register indices, field positions, reset values and timing counts
// Assumes a 25 MHz clock and a 32-bit Wishbone word per register
`ifndef DOWA_MAP_SVH
`define DOWA_MAP_SVH

// Register indices; byte address is four times the index
`define DOWA_IDX_CTRL      8'h01
`define DOWA_IDX_CLAMP     8'h02
`define DOWA_IDX_CODE      8'h03
`define DOWA_IDX_MASK      8'h04
`define DOWA_IDX_STATUS    8'h05
`define DOWA_IDX_IMASK     8'h06
`define DOWA_IDX_ALMCODE   8'h0e
`define DOWA_IDX_WDSERV    8'h10
`define DOWA_IDX_RSVD_LO   8'h12

// Control fields
`define DOWA_CTRL_VOLTAGE_OUTPUT_PIN     0
`define DOWA_CTRL_CURRENT_OUTPUT_PIN     1
`define DOWA_CTRL_POC      2
`define DOWA_CTRL_MODE_LO  3
`define DOWA_CTRL_ACT_LO   6
`define DOWA_CTRL_WDT_EN   8

// Alarm mask fields
`define DOWA_MASK_WDT      11
`define DOWA_MASK_CRC      5

// Status and interrupt mask fields
`define DOWA_ST_WDT        0
`define DOWA_ST_CRC        1
`define DOWA_ST_LEARN      2

// Watchdog service restart bit
`define DOWA_WDS_RESTART   0

// Alarm code field low bit within the code word
`define DOWA_ACODE_LO      10

// Reset values
`define DOWA_RST_CTRL      16'h0000
`define DOWA_RST_CLAMP     8'hff
`define DOWA_RST_WDSERV    16'h0000

// Auto-learn threshold and load margin
`define DOWA_LEARN_THRESH  16'h4000
`define DOWA_LEARN_MARGIN  8'h08

// Watchdog period
`define DOWA_WDT_TIME_US   10000
`define DOWA_CLK_MHZ       25

`endif

// >>> hdl/dowa_pkg.sv
// Types shared by the output-control block and its helpers
// Assumes dowa_map.svh supplies all numbers except the clamp width DOWA_CLAMP_W
package dowa_pkg;

   localparam int DOWA_CLAMP_W = 8;

   typedef enum logic [1:0] {
      DOWA_BB_OFF,
      DOWA_BB_TRACK,
      DOWA_BB_CLAMP,
      DOWA_BB_RSVD
   } dowa_bbmode_t;

   typedef enum logic [1:0] {
      DOWA_ACT_NONE,
      DOWA_ACT_CODE,
      DOWA_ACT_SHUT,
      DOWA_ACT_INVALID
   } dowa_action_t;

   typedef enum logic [1:0] {
      DOWA_LRN_IDLE,
      DOWA_LRN_WAIT,
      DOWA_LRN_HELD
   } dowa_lrn_state_t;

endpackage : dowa_pkg

// >>> hdl/dowa_wdog.sv
// Watchdog counter: one-cycle timeout pulse when no restart arrives in time
// Assumes restart_i and enable_i come from logic on the same clock
`timescale 1ns/1ps
module dowa_wdog
   import dowa_pkg::*;
#(
   parameter int unsigned PERIOD = 250000
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   input  wire logic restart_i,
   output logic      timeout_o
);

   initial begin
      if (PERIOD < 2) $error("dowa_wdog: PERIOD too short");
   end

   typedef struct packed {
      logic [31:0] cnt;
      logic        timeout;
   } dowa_wd_state_t;

   dowa_wd_state_t s_q;
   dowa_wd_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.timeout = 1'b0;
      if (!enable_i || restart_i) begin
         s_d.cnt = 32'h0000_0000;
      end else if (s_q.cnt == 32'(PERIOD - 1)) begin
         s_d.timeout = 1'b1;
         s_d.cnt = 32'h0000_0000;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign timeout_o = s_q.timeout;

endmodule : dowa_wdog

// >>> hdl/dowa_learn.sv
// Buck-boost auto-learn: picks one clamp from the sensed load once the code passes the threshold
// Assumes load_i is already synchronised to clk_i
`timescale 1ns/1ps
`include "dowa_map.svh"
module dowa_learn
   import dowa_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    current_output_pin_en_i,
   input  dowa_bbmode_t                 mode_i,
   input  wire logic [15:0]             code_i,
   input  wire logic [DOWA_CLAMP_W-1:0] host_clamp_i,
   input  wire logic [DOWA_CLAMP_W-1:0] load_i,
   output logic      [DOWA_CLAMP_W-1:0] clamp_o,
   output logic                         learned_o
);

   typedef struct packed {
      dowa_lrn_state_t         st;
      logic [DOWA_CLAMP_W-1:0] clamp;
      logic                    learned;
   } dowa_lrn_t;

   dowa_lrn_t s_q;
   dowa_lrn_t s_d;
   logic [DOWA_CLAMP_W:0] want;

   always_comb begin
      s_d = s_q;
      s_d.learned = 1'b0;
      want = {1'b0, load_i} + {1'b0, `DOWA_LEARN_MARGIN};
      unique case (s_q.st)
         DOWA_LRN_IDLE: begin
            s_d.clamp = host_clamp_i;
            if (current_output_pin_en_i && mode_i == DOWA_BB_TRACK) begin
               s_d.st = DOWA_LRN_WAIT;
            end
         end
         DOWA_LRN_WAIT: begin
            s_d.clamp = host_clamp_i;
            if (!current_output_pin_en_i || mode_i != DOWA_BB_TRACK) begin
               s_d.st = DOWA_LRN_IDLE;
            end else if (code_i > `DOWA_LEARN_THRESH) begin
               s_d.clamp = want[DOWA_CLAMP_W] ? '1 : want[DOWA_CLAMP_W-1:0];
               s_d.learned = 1'b1;
               s_d.st = DOWA_LRN_HELD;
            end
         end
         DOWA_LRN_HELD: begin
            if (!current_output_pin_en_i || mode_i != DOWA_BB_TRACK) begin
               s_d.st = DOWA_LRN_IDLE;
            end
         end
         // Unused fourth code falls back to idle
         default: begin
            s_d.st = DOWA_LRN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.st <= DOWA_LRN_IDLE;
         s_q.clamp <= `DOWA_RST_CLAMP;
         s_q.learned <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign clamp_o = s_q.clamp;
   assign learned_o = s_q.learned;

endmodule : dowa_learn

// >>> bench/dowa_top_asserts.sv
// Bus, reset and steering relations of dowa_top, seen at its ports only
// Assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ps
module dowa_top_asserts
   import dowa_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [9:0]              wb_adr_i,
   input  logic      [31:0]             wb_dat_o,
   input  logic                         wb_ack_o,
   input  logic                         current_output_pin_hiz_o,
   input  logic      [3:0]              vsw_closed_o,
   input  logic      [DOWA_CLAMP_W-1:0] bb_clamp_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Recent acked writes; learning may lag its write by a few cycles
   logic [3:0] wr_ack_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ack_q <= 4'h0;
      end else begin
         wr_ack_q <= {wr_ack_q[2:0], wb_ack_o & wb_we_i};
      end
   end

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

   property p_wds_zero;
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h10 |-> wb_dat_o == 32'h0;
   endproperty
   a_wds_zero: assert property (p_wds_zero) else $error("service register read nonzero");

   property p_rsvd_zero;
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] >= 8'h12 |-> wb_dat_o == 32'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read nonzero");

   property p_upper_zero;
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

   property p_reset_vals;
      $fell(rst_i) |-> !wb_ack_o && current_output_pin_hiz_o && vsw_closed_o == 4'b0100 && bb_clamp_o == 8'hff;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("wrong values after reset");

   property p_vsw_group;
      vsw_closed_o[0] == vsw_closed_o[1] && vsw_closed_o[1] == vsw_closed_o[3];
   endproperty
   a_vsw_group: assert property (p_vsw_group) else $error("switches 1 2 4 disagree");

   property p_vsw_third;
      vsw_closed_o[0] |-> vsw_closed_o[2];
   endproperty
   a_vsw_third: assert property (p_vsw_third) else $error("third switch open with output on");

   property p_clamp_cause;
      $changed(bb_clamp_o) |-> wr_ack_q != 4'h0;
   endproperty
   a_clamp_cause: assert property (p_clamp_cause) else $error("clamp moved without a write");
endmodule : dowa_top_asserts

bind dowa_top dowa_top_asserts u_chk (
   .clk_i        (clk_i),
   .rst_i        (rst_i),
   .wb_cyc_i     (wb_cyc_i),
   .wb_stb_i     (wb_stb_i),
   .wb_we_i      (wb_we_i),
   .wb_adr_i     (wb_adr_i),
   .wb_dat_o     (wb_dat_o),
   .wb_ack_o     (wb_ack_o),
   .current_output_pin_hiz_o   (current_output_pin_hiz_o),
   .vsw_closed_o (vsw_closed_o),
   .bb_clamp_o   (bb_clamp_o)
);

// >>> bench/dowa_host.sv
// Host model: classic Wishbone single-cycle master for the register bus
// Assumes the slave acks every request; the bench timeout ends a hang
`timescale 1ns/1ps
module dowa_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o = 1'b0,
   output logic             stb_o = 1'b0,
   output logic             we_o  = 1'b0,
   output logic      [9:0]  adr_o = 10'h000,
   output logic      [3:0]  sel_o = 4'h0,
   output logic      [31:0] dat_o = 32'h0
);
   task automatic req(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= {idx, 2'b00};
      sel_o <= 4'h3;
      dat_o <= {16'h0000, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i[15:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= 1'b0;
   endtask : req

   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic [15:0] q;
      req(1'b1, idx, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [15:0] q);
      req(1'b0, idx, 16'h0000, q);
   endtask : rd
endmodule : dowa_host

// >>> bench/dowa_top_bench.sv
// Self-checking bench for dowa_top: steering table, then hand tests
// Assumes the host model drives the bus; watchdog period shortened to 20
`timescale 1ns/1ps
`include "dowa_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module dowa_top_bench
   import dowa_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        crc_err_i = 1'b0;
   logic [7:0]  load_level_i = 8'h30;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, vsw_closed_o;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        current_output_pin_hiz_o, alarm_o, irq_o, bb_en_o, bb_track_o, dac_en_o;
   logic [7:0]  bb_clamp_o;
   logic [15:0] dac_code_o, rv;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cyc_n = 0;
   logic [15:0] st_ctl [5] = '{16'h0001, 16'h0002, 16'h0006, 16'h0003, 16'h0004};
   logic [5:0]  st_exp [5] = '{6'h3f, 6'h24, 6'h20, 6'h2f, 6'h10};
   logic [7:0]  rs [3]     = '{8'h12, 8'h81, 8'hff};
   logic [1:0]  acts [4]   = '{2'b00, 2'b11, 2'b01, 2'b10};
   logic [15:0] acode [3]  = '{16'h1234, 16'h1234, 16'hfc00};

   dowa_top #(.WDT_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
                                      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
                                      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
                                      .crc_err_i(crc_err_i), .load_level_i(load_level_i),
                                      .current_output_pin_hiz_o(current_output_pin_hiz_o), .vsw_closed_o(vsw_closed_o),
                                      .alarm_o(alarm_o), .irq_o(irq_o), .bb_en_o(bb_en_o),
                                      .bb_track_o(bb_track_o), .bb_clamp_o(bb_clamp_o),
                                      .dac_en_o(dac_en_o), .dac_code_o(dac_code_o));
   dowa_host u_host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
                     .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

   always #20 clk_i = ~clk_i;

   // Whole run needs well under 1000 cycles
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : w

   task automatic rst_go();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : rst_go

   initial begin
      rst_go();
      w(1);
      u_host.rd(`DOWA_IDX_WDSERV, rv);
      `CHK("wds_rst", `DOWA_RST_WDSERV, rv)
      `CHK("vsw_rst", 4'b0100, vsw_closed_o)
      for (int i = 0; i < 5; i++) begin
         u_host.wr(`DOWA_IDX_CTRL, st_ctl[i]);
         w(2);
         `CHK("steer", st_exp[i], {dac_en_o, current_output_pin_hiz_o, vsw_closed_o})
      end
      for (int i = 0; i < 3; i++) begin
         u_host.wr(rs[i], 16'hffff);
         u_host.rd(rs[i], rv);
         `CHK("rsvd", 16'h0000, rv)
      end
      u_host.rd(`DOWA_IDX_CTRL, rv);
      `CHK("ctrl_kept", 16'h0004, rv)
      // Restarts spaced well inside the period
      u_host.wr(`DOWA_IDX_CTRL, 16'h0100);
      repeat (5) begin
         w(10);
         u_host.wr(`DOWA_IDX_WDSERV, 16'h0001);
      end
      u_host.rd(`DOWA_IDX_WDSERV, rv);
      `CHK("wds_clear", 16'h0000, rv)
      u_host.rd(`DOWA_IDX_STATUS, rv);
      `CHK("wdt_early", 16'h0000, rv)
      w(25);
      u_host.rd(`DOWA_IDX_STATUS, rv);
      `CHK("wdt_flag", 1'b1, rv[0])
      `CHK("alarm_on", 1'b1, alarm_o)
      `CHK("irq_masked", 1'b0, irq_o)
      u_host.wr(`DOWA_IDX_IMASK, 16'h0001);
      u_host.wr(`DOWA_IDX_MASK, 16'h0800);
      w(2);
      `CHK("irq_on", 1'b1, irq_o)
      `CHK("alarm_mask", 1'b0, alarm_o)
      u_host.wr(`DOWA_IDX_CTRL, 16'h0000);
      u_host.wr(`DOWA_IDX_STATUS, 16'h0007);
      w(2);
      `CHK("irq_clr", 1'b0, irq_o)
      u_host.wr(`DOWA_IDX_ALMCODE, 16'hfc00);
      u_host.wr(`DOWA_IDX_CODE, 16'h1234);
      for (int i = 0; i < 4; i++) begin
         u_host.wr(`DOWA_IDX_CTRL, {8'h00, acts[i], 6'h01});
         u_host.wr(`DOWA_IDX_STATUS, 16'h0007);
         @(posedge clk_i);
         crc_err_i <= 1'b1;
         @(posedge clk_i);
         crc_err_i <= 1'b0;
         w(3);
         if (i < 3) `CHK("act_code", acode[i], dac_code_o)
         `CHK("act_en", (i != 3), dac_en_o)
      end
      // Shutdown must survive a fresh enable
      u_host.wr(`DOWA_IDX_CTRL, 16'h0001);
      w(2);
      `CHK("shut_hold", 3'b010, {dac_en_o, current_output_pin_hiz_o, bb_en_o})
      rst_go();
      u_host.wr(`DOWA_IDX_CTRL, 16'h0001);
      w(2);
      `CHK("shut_reset", 1'b1, dac_en_o)
      u_host.wr(`DOWA_IDX_CLAMP, 16'h00c0);
      // Second entry: clamp mode, current on, then tracking
      u_host.wr(`DOWA_IDX_CTRL, 16'h0010);
      u_host.wr(`DOWA_IDX_CTRL, 16'h0012);
      w(2);
      `CHK("clamp_mode", 2'b10, {bb_en_o, bb_track_o})
      u_host.wr(`DOWA_IDX_CTRL, 16'h000a);
      u_host.wr(`DOWA_IDX_CODE, 16'h4000);
      w(4);
      `CHK("clamp_held", 8'hc0, bb_clamp_o)
      `CHK("track_on", 2'b11, {bb_en_o, bb_track_o})
      u_host.wr(`DOWA_IDX_CODE, 16'h4001);
      w(4);
      `CHK("clamp_learn", 8'h38, bb_clamp_o)
      u_host.rd(`DOWA_IDX_STATUS, rv);
      `CHK("learn_flag", 1'b1, rv[2])
      @(posedge clk_i);
      load_level_i <= 8'hfa;
      u_host.wr(`DOWA_IDX_CODE, 16'hffff);
      u_host.wr(`DOWA_IDX_CODE, 16'h0001);
      w(4);
      `CHK("clamp_fixed", 8'h38, bb_clamp_o)
      // First entry: tracking before current on; load plus margin saturates
      u_host.wr(`DOWA_IDX_CTRL, 16'h0008);
      u_host.wr(`DOWA_IDX_CODE, 16'h0000);
      w(1);
      `CHK("track_first", 2'b11, {bb_en_o, bb_track_o})
      u_host.wr(`DOWA_IDX_CTRL, 16'h000a);
      u_host.wr(`DOWA_IDX_CODE, 16'h4001);
      w(4);
      `CHK("clamp_sat", 8'hff, bb_clamp_o)
      test_done();
   end
endmodule : dowa_top_bench
